// file: rtl/ispfb_flash_access.sv
// ispfb_flash_access.sv: in-system-programming flash sequencer and code banking
// assumes: 50 MHz clock_i, flash arrays answer reads in one cycle, cpu idle
// handshake from the core
//
// Operation
// - high and low registers form 16-bit address
// - flash data passes through data buffer register
// - bank bit one selects bank one when window bit is clear
// - window bit selects application or loader flash
// - erase code 0010 clears whole array
// - program code 0001 writes buffer to address
// - read code 0000 returns byte to buffer
// - banking enable uses port-1 pin as A16
// - A16 chooses fetch bank zero or one
// - pin select 000-111 picks pin, default 7
// - while isp enabled, idle request also starts the op
`timescale 1ns/1ps
`default_nettype none
`include "ispfb_regs.svh"

module ispfb_flash_access #(
  parameter int ERASE_CYCLES = `ISPFB_ERASE_CYCLES,
  parameter int PROG_CYCLES = `ISPFB_PROG_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  // cpu idle handshake
  input wire logic cpu_idle_request_i,
  output logic cpu_idle_o,
  output logic restart_area_select_o,
  // port-1 pins and code fetch bank
  input wire logic [7:0] port1_pin_i,
  output logic fetch_bank_o,
  output logic banking_enable_o,
  // flash array port
  output logic [15:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  output logic [1:0] flash_array_o,
  output logic flash_read_o,
  output logic flash_program_o,
  output logic flash_erase_o,
  input wire logic [7:0] flash_rdata_i
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] code_bank_control;
    logic [7:0] isp_address_low;
    logic [7:0] isp_address_high;
    logic [7:0] isp_data_buffer;
    logic [7:0] isp_operation_control;
    logic isp_enable;
    logic restart_area_select;
    logic done_flag;
    ispfb_pkg::ispfb_state_e state;
    logic [31:0] count;
    logic [7:0] rdata;
    logic cpu_idle;
    logic fetch_bank;
    logic [15:0] flash_addr;
    logic [7:0] flash_wdata;
    logic [1:0] flash_array;
    logic flash_read;
    logic flash_program;
    logic flash_erase;
  } ispfb_state_s;

  ispfb_state_s cur;
  ispfb_state_s next_cur;
  logic [7:0] pins;

  // port-1 pins synchronised
  ispfb_a16_sync #(
    .WIDTH(8)
  ) u_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .pin_i(port1_pin_i),
    .sync_o(pins)
  );

  // picks the target array from bank and window bits
  function automatic logic [1:0] ispfb_target(input logic [7:0] op);
    logic [1:0] arr;
    arr = 2'(ispfb_pkg::ISPFB_ARR_BANK0);
    if (op[`ISPFB_OP_WINDOW_BIT])
      arr = 2'(ispfb_pkg::ISPFB_ARR_LOADER);
    else if (op[`ISPFB_OP_BANK_BIT])
      arr = 2'(ispfb_pkg::ISPFB_ARR_BANK1);
    return arr;
  endfunction

  // checks the enable strobes and code of the operation word
  function automatic logic ispfb_is_op(input logic [7:0] op, input logic oe_n,
                                       input logic [3:0] code);
    return (op[`ISPFB_OP_OE_N_BIT] == oe_n) && !op[`ISPFB_OP_CE_N_BIT]
           && (op[3:0] == code);
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.rdata = 8'h00;
    next_cur.flash_read = 1'b0;
    next_cur.flash_program = 1'b0;
    next_cur.flash_erase = 1'b0;

    // register writes
    if (reg_write_i)
    begin
      case (reg_addr_i)
        `ISPFB_OFS_CODE_BANK_CONTROL: next_cur.code_bank_control = {4'h0, reg_wdata_i[3:0]};
        `ISPFB_OFS_ISP_ADDRESS_LOW: next_cur.isp_address_low = reg_wdata_i;
        `ISPFB_OFS_ISP_ADDRESS_HIGH: next_cur.isp_address_high = reg_wdata_i;
        `ISPFB_OFS_ISP_DATA_BUFFER: next_cur.isp_data_buffer = reg_wdata_i;
        `ISPFB_OFS_ISP_OPERATION_CONTROL: next_cur.isp_operation_control = reg_wdata_i;
        `ISPFB_OFS_ISP_CONTROL:
        begin
          next_cur.isp_enable = reg_wdata_i[`ISPFB_CTL_ENABLE_BIT];
          next_cur.restart_area_select = reg_wdata_i[`ISPFB_CTL_RESTART_BIT];
        end
        `ISPFB_OFS_ISP_STATUS: next_cur.done_flag = 1'b0; // any write clears
        default: ;
      endcase
    end

    // register reads, data one cycle later
    if (reg_read_i)
    begin
      case (reg_addr_i)
        `ISPFB_OFS_CODE_BANK_CONTROL: next_cur.rdata = cur.code_bank_control;
        `ISPFB_OFS_ISP_ADDRESS_LOW: next_cur.rdata = cur.isp_address_low;
        `ISPFB_OFS_ISP_ADDRESS_HIGH: next_cur.rdata = cur.isp_address_high;
        `ISPFB_OFS_ISP_DATA_BUFFER: next_cur.rdata = cur.isp_data_buffer;
        `ISPFB_OFS_ISP_OPERATION_CONTROL: next_cur.rdata = cur.isp_operation_control;
        `ISPFB_OFS_ISP_CONTROL:
          next_cur.rdata = {6'h00, cur.restart_area_select, cur.isp_enable};
        `ISPFB_OFS_ISP_STATUS:
          next_cur.rdata = {5'h00, cur.cpu_idle, cur.state == ispfb_pkg::ISPFB_RUN,
                            cur.done_flag};
        default: next_cur.rdata = 8'h00;
      endcase
    end

    // sequencer
    case (cur.state)
      ispfb_pkg::ISPFB_IDLE:
      begin
        // idle request always sets idle; with isp enabled it also starts the op
        if (cpu_idle_request_i)
          next_cur.cpu_idle = 1'b1;
        else if (!cur.isp_enable)
          next_cur.cpu_idle = 1'b0;
        if (cpu_idle_request_i && cur.isp_enable)
        begin
          next_cur.cpu_idle = 1'b1;
          next_cur.flash_addr = {cur.isp_address_high, cur.isp_address_low};
          next_cur.flash_wdata = cur.isp_data_buffer;
          next_cur.flash_array = ispfb_target(cur.isp_operation_control);
          next_cur.count = 32'd0;
          if (ispfb_is_op(cur.isp_operation_control, 1'b1, `ISPFB_CODE_ERASE))
          begin
            next_cur.flash_erase = 1'b1;
            next_cur.count = 32'(ERASE_CYCLES);
            next_cur.state = ispfb_pkg::ISPFB_RUN;
          end
          else if (ispfb_is_op(cur.isp_operation_control, 1'b1, `ISPFB_CODE_PROGRAM))
          begin
            next_cur.flash_program = 1'b1;
            next_cur.count = 32'(PROG_CYCLES);
            next_cur.state = ispfb_pkg::ISPFB_RUN;
          end
          else if (ispfb_is_op(cur.isp_operation_control, 1'b0, `ISPFB_CODE_READ))
          begin
            next_cur.flash_read = 1'b1;
            next_cur.count = 32'd1;
            next_cur.state = ispfb_pkg::ISPFB_RUN;
          end
          else
            next_cur.state = ispfb_pkg::ISPFB_DONE; // unknown word: no flash action
        end
      end
      ispfb_pkg::ISPFB_RUN:
      begin
        if (cur.count <= 32'd1)
        begin
          // read data lands in the buffer for every target array
          if (ispfb_is_op(cur.isp_operation_control, 1'b0, `ISPFB_CODE_READ))
            next_cur.isp_data_buffer = flash_rdata_i;
          next_cur.state = ispfb_pkg::ISPFB_DONE;
        end
        else
          next_cur.count = cur.count - 32'd1;
      end
      ispfb_pkg::ISPFB_DONE:
      begin
        next_cur.done_flag = 1'b1;
        next_cur.cpu_idle = 1'b0;
        next_cur.state = ispfb_pkg::ISPFB_IDLE;
      end
      default: next_cur.state = ispfb_pkg::ISPFB_IDLE;
    endcase

    // fetch bank from selected pin when banking is on
    if (cur.code_bank_control[`ISPFB_BANKING_ENABLE_BIT])
      next_cur.fetch_bank = pins[cur.code_bank_control[2:0]];
    else
      next_cur.fetch_bank = 1'b0;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cur <= '0;
      cur.code_bank_control <= `ISPFB_RST_CODE_BANK_CONTROL;
      cur.state <= ispfb_pkg::ISPFB_IDLE;
    end
    else
      cur <= next_cur;
  end

  // outputs straight from flops
  assign reg_rdata_o = cur.rdata;
  assign cpu_idle_o = cur.cpu_idle;
  assign restart_area_select_o = cur.restart_area_select;
  assign fetch_bank_o = cur.fetch_bank;
  assign banking_enable_o = cur.code_bank_control[`ISPFB_BANKING_ENABLE_BIT];
  assign flash_addr_o = cur.flash_addr;
  assign flash_wdata_o = cur.flash_wdata;
  assign flash_array_o = cur.flash_array;
  assign flash_read_o = cur.flash_read;
  assign flash_program_o = cur.flash_program;
  assign flash_erase_o = cur.flash_erase;

endmodule
`default_nettype wire

// file: include/ispfb_regs.svh
// ispfb_regs.svh: register offsets, field positions, reset values and timing counts
// assumes: included by the flash access block and its package users
`ifndef ISPFB_REGS_SVH
`define ISPFB_REGS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses on the register port)
// ------------------------------------------------------------
`define ISPFB_OFS_CODE_BANK_CONTROL 8'hAB
`define ISPFB_OFS_ISP_ADDRESS_LOW 8'hAC
`define ISPFB_OFS_ISP_ADDRESS_HIGH 8'hAD
`define ISPFB_OFS_ISP_DATA_BUFFER 8'hAE
`define ISPFB_OFS_ISP_OPERATION_CONTROL 8'hAF
`define ISPFB_OFS_ISP_CONTROL 8'hB0
`define ISPFB_OFS_ISP_STATUS 8'hB1

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ISPFB_BANKING_ENABLE_BIT 3
`define ISPFB_OP_BANK_BIT 7
`define ISPFB_OP_WINDOW_BIT 6
`define ISPFB_OP_OE_N_BIT 5
`define ISPFB_OP_CE_N_BIT 4
`define ISPFB_CTL_ENABLE_BIT 0
`define ISPFB_CTL_RESTART_BIT 1

// ------------------------------------------------------------
// control codes and reset values
// ------------------------------------------------------------
`define ISPFB_CODE_READ 4'h0
`define ISPFB_CODE_PROGRAM 4'h1
`define ISPFB_CODE_ERASE 4'h2
`define ISPFB_RST_CODE_BANK_CONTROL 8'h07
`define ISPFB_RST_ZERO 8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define ISPFB_CLK_MHZ 50
`define ISPFB_PROG_TIME_US 20
`define ISPFB_ERASE_TIME_US 10000
`define ISPFB_PROG_CYCLES (`ISPFB_PROG_TIME_US * `ISPFB_CLK_MHZ)
`define ISPFB_ERASE_CYCLES (`ISPFB_ERASE_TIME_US * `ISPFB_CLK_MHZ)

`endif

// file: include/ispfb_pkg.sv
// ispfb_pkg.sv: types shared by the flash access block
// assumes: constants come from ispfb_regs.svh
package ispfb_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    ISPFB_IDLE,
    ISPFB_RUN,
    ISPFB_DONE
  } ispfb_state_e;

  // target array
  typedef enum logic [1:0] {
    ISPFB_ARR_BANK0,
    ISPFB_ARR_BANK1,
    ISPFB_ARR_LOADER
  } ispfb_array_e;

endpackage

// file: rtl/ispfb_a16_sync.sv
// ispfb_a16_sync.sv: two-stage synchroniser for the port-1 pins
// assumes: pins are asynchronous to clock_i
`timescale 1ns/1ps
`default_nettype none

module ispfb_a16_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // two flops, the first read only by the second
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta <= pin_i;
      sync_o <= meta;
    end
  end

endmodule
`default_nettype wire

// file: tb/ispfb_chk_properties.sv
// ispfb_chk_properties.sv: port assertions for the flash access block
// assumes: bound into ispfb_flash_access, one clock domain
`timescale 1ns/1ps
`default_nettype none

module ispfb_chk (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // observed ports
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic cpu_idle_request_i,
  input wire logic cpu_idle_o,
  input wire logic [7:0] port1_pin_i,
  input wire logic fetch_bank_o,
  input wire logic banking_enable_o,
  input wire logic [1:0] flash_array_o,
  input wire logic flash_read_o,
  input wire logic flash_program_o,
  input wire logic flash_erase_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // ----
  // properties
  // ----
  // strobes, idle and fetch bank against their causes
  chk_read_release: assert property (flash_read_o |-> cpu_idle_o ##2 !cpu_idle_o)
    else $error("read op kept idle");
  chk_one_strobe: assert property ($onehot0({flash_read_o, flash_program_o, flash_erase_o}))
    else $error("two flash strobes");
  chk_strobe_cause: assert property ((flash_read_o || flash_program_o || flash_erase_o)
    |-> $past(cpu_idle_request_i) && cpu_idle_o)
    else $error("strobe without idle entry");
  chk_array_legal: assert property ((flash_program_o || flash_erase_o) |-> flash_array_o != 2'h3)
    else $error("bad target array");
  chk_prog_holds: assert property (flash_program_o |=> cpu_idle_o [*2])
    else $error("idle dropped in program");
  chk_rdata_quiet: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside slot");
  chk_fetch_off: assert property (!banking_enable_o && $past(!banking_enable_o) |-> !fetch_bank_o)
    else $error("fetch bank with banking off");
  chk_fetch_high: assert property ((banking_enable_o && port1_pin_i == 8'hFF) [*4] |-> fetch_bank_o)
    else $error("fetch bank not one");
  chk_fetch_low: assert property ((banking_enable_o && port1_pin_i == 8'h00) [*4] |-> !fetch_bank_o)
    else $error("fetch bank not zero");
endmodule

bind ispfb_flash_access ispfb_chk ispfb_chk_i (.*);

`default_nettype wire

// file: tb/ispfb_flash_model.sv
// ispfb_flash_model.sv: three flash arrays behind the block's flash port
// assumes: read data is taken in the strobe cycle or the one after
`timescale 1ns/1ps
`default_nettype none

module ispfb_flash_model (
  // clock
  input wire logic clock_i,
  // flash port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] array_i,
  input wire logic read_i,
  input wire logic program_i,
  input wire logic erase_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:2][0:65535];
  logic [7:0] junk = 8'h00;
  logic [7:0] kept = 8'h00;
  logic held = 1'b0;
  // arrays start erased
  initial
    foreach (mem[a, b])
      mem[a][b] = 8'hFF;
  // program a byte, erase a whole array, keep read data one cycle
  always @(posedge clock_i)
  begin
    junk <= ~junk;
    held <= read_i;
    kept <= mem[array_i][addr_i];
    if (program_i)
      mem[array_i][addr_i] <= wdata_i;
    if (erase_i)
      for (int k = 0; k < 65536; k++)
        mem[array_i][k] <= 8'hFF;
  end
  // released data lines toggle
  assign rdata_o = read_i ? mem[array_i][addr_i] : (held ? kept : junk);
endmodule

`default_nettype wire

// file: tb/ispfb_flash_access_bench.sv
// ispfb_flash_access_bench.sv: register tasks, flash op table, banking sweep
// assumes: flash model and checker compiled before
`timescale 1ns/1ps
`default_nettype none

module ispfb_flash_access_bench;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] a = 8'h00;
  logic [7:0] d = 8'h00;
  logic w = 1'b0;
  logic r = 1'b0;
  logic req = 1'b0;
  logic [7:0] pins = 8'h00;
  logic [7:0] rdata, frd, fwd;
  logic [15:0] fa;
  logic [1:0] farr;
  logic idle, restart, fetch, ben, fr, fp, fe;
  int errors = 0;
  int compares = 0;
  // address, data, op word, expected buffer
  logic [39:0] ops [9] = '{40'h12345AA15A, 40'h0FFFA561A5, 40'h123400805A,
    40'h12340000FF, 40'h0FFF0040A5, 40'h123400A200, 40'h12340080FF,
    40'h0FFF0040A5, 40'h0000330F33};

  ispfb_flash_access #(.ERASE_CYCLES(5), .PROG_CYCLES(3)) ispfb_flash_access_i (
    .clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(a), .reg_wdata_i(d),
    .reg_write_i(w), .reg_read_i(r), .reg_rdata_o(rdata),
    .cpu_idle_request_i(req), .cpu_idle_o(idle), .restart_area_select_o(restart),
    .port1_pin_i(pins), .fetch_bank_o(fetch), .banking_enable_o(ben),
    .flash_addr_o(fa), .flash_wdata_o(fwd), .flash_array_o(farr),
    .flash_read_o(fr), .flash_program_o(fp), .flash_erase_o(fe),
    .flash_rdata_i(frd));
  ispfb_flash_model ispfb_flash_model_i (.clock_i(clock_i), .addr_i(fa),
    .wdata_i(fwd), .array_i(farr), .read_i(fr), .program_i(fp), .erase_i(fe),
    .rdata_o(frd));

  // clock
  initial
  begin
    forever #10 clock_i = ~clock_i;
  end
  // ----
  // tasks
  // ----
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] ad, input logic [7:0] dd);
    @(posedge clock_i);
    a <= ad;
    d <= dd;
    w <= 1'b1;
    @(posedge clock_i);
    w <= 1'b0;
  endtask
  // data stands in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clock_i);
    a <= ad;
    r <= 1'b1;
    @(posedge clock_i);
    r <= 1'b0;
    #1 check("rdata", e, rdata);
  endtask
  // load registers, pulse the idle request, wait for release
  task automatic run_op(input logic [39:0] e);
    int n;
    reg_wr(8'hAD, e[39:32]);
    reg_wr(8'hAC, e[31:24]);
    reg_wr(8'hAE, e[23:16]);
    reg_wr(8'hAF, e[15:8]);
    @(posedge clock_i);
    req <= 1'b1;
    @(posedge clock_i);
    req <= 1'b0;
    #1;
    for (n = 0; n < 40 && idle !== 1'b0; n++)
    begin
      @(posedge clock_i);
      #1;
    end
    if (n == 40)
    begin
      errors++;
      tally_and_finish();
    end
    if (e[11:9] == 3'h0)
    begin
      check("addr", e[39:24], fa);
      check("array", e[14] ? 2'h2 : {1'b0, e[15]}, farr);
    end
    reg_rd(8'hAE, e[7:0]);
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (6) @(posedge clock_i);
    rstn_i <= 1'b1;
    reg_rd(8'hAB, 8'h07);
    for (int k = 8'hAC; k <= 8'hB0; k++)
      reg_rd(k[7:0], 8'h00);
    reg_rd(8'hC3, 8'h00);
    $display("test reset values done");
    reg_wr(8'hB0, 8'h03);
    #1 check("restart", 1'b1, restart);
    foreach (ops[i])
      run_op(ops[i]);
    $display("test flash ops done");
    for (int s = 0; s < 8; s++)
    begin
      reg_wr(8'hAB, 8'h08 | s[7:0]);
      pins <= 8'h01 << s;
      repeat (5) @(posedge clock_i);
      check("fetch", 1'b1, fetch);
      pins <= ~(8'h01 << s);
      repeat (5) @(posedge clock_i);
      check("fetch", 1'b0, fetch);
    end
    reg_rd(8'hAB, 8'h0F);
    pins <= 8'h00;
    repeat (5) @(posedge clock_i);
    pins <= 8'hFF;
    repeat (5) @(posedge clock_i);
    reg_wr(8'hAB, 8'h07);
    repeat (5) @(posedge clock_i);
    check("fetch", 1'b0, fetch);
    check("banking", 1'b0, ben);
    $display("test banking done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
